// >>> hdl/sensor_port_device.sv
// Purpose: serial slave port (SPI mode 3 or I2C) over a register file
// Assumes: link pins synchronised into sys_clk, link far slower than clock
// Notes:   sdi doubles as i2c data, sclk as i2c clock; sdioIn is shared pin
//
// Contract
// - measure bit cleared means standby, no sampling
// - standby keeps stored sample buffer intact
// - measure bit set enters measurement, clear returns
// - device is slave only, never initiates
// - chip-select high enables i2c, low selects spi
// - i2c-like traffic with chip-select high answered
// - master ORs data-in with chip-select
// - master ignores device output during writes
// - wire-count bit picks 4-wire or 3-wire
// - mode 3: sample rising, shift falling
// - output shifts on falling, released after deselect
// - host raises chip-select before changing mode
// - master frames with chip-select, supplies clock
// - first byte: read flag, burst flag, address
// - burst advances pointer every eight clocks
// - non-consecutive access needs a new frame
// - master keeps link clock above rate minimum
// - i2c needs chip-select high, id pin tied
// - i2c address picked by id select pin
module sensor_port_device #(
  parameter int REG_COUNT = 64
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // link
  sensor_link_if.device   link,
  // user side
  output logic            measuring,
  output logic            sampleEnable,
  output logic            sampleClear,
  output logic [7:0]      powerControl,
  output logic [7:0]      layoutConfig
);
  // ****************************************
  // synchronisers
  // ****************************************
  logic [1:0] csSync_ff, clkSync_ff, sdiSync_ff, sdioSync_ff, sdaSync_ff;
  logic       clkPrev_ff, sdaPrev_ff;
  logic [1:0] idSync_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      csSync_ff   <= 2'h3;
      clkSync_ff  <= 2'h3;
      sdiSync_ff  <= 2'h3;
      sdioSync_ff <= 2'h3;
      sdaSync_ff  <= 2'h3;
      idSync_ff   <= 2'h3;
      clkPrev_ff  <= 1'b1;
      sdaPrev_ff  <= 1'b1;
    end else begin
      csSync_ff   <= {csSync_ff[0], link.csN};
      clkSync_ff  <= {clkSync_ff[0], link.sclk};
      sdiSync_ff  <= {sdiSync_ff[0], link.sdi};
      sdioSync_ff <= {sdioSync_ff[0], link.sdioIn};
      sdaSync_ff  <= {sdaSync_ff[0], link.sdaIn};
      idSync_ff   <= {idSync_ff[0], link.busIdSelectPin};
      clkPrev_ff  <= clkSync_ff[1];
      sdaPrev_ff  <= sdaSync_ff[1];
    end
  end
  logic csHigh, clkRise, clkFall, clkHigh, i2cStart, i2cStop;
  logic wire3, dataBit, sdaBit;
  assign csHigh  = csSync_ff[1];
  assign clkHigh = clkSync_ff[1];
  assign clkRise = clkSync_ff[1] & ~clkPrev_ff;
  assign clkFall = ~clkSync_ff[1] & clkPrev_ff;
  // ****************************************
  // registers
  // ****************************************
  logic [7:0] regs_ff [REG_COUNT];
  logic       regWrite;
  logic [5:0] regAddr;
  logic [7:0] regWdata;
  assign wire3   = regs_ff[sensor_port_pkg::SAMPLE_LAYOUT_CONFIG_ADDR]
                   [sensor_port_pkg::WIRE3_BIT];
  assign dataBit = wire3 ? sdioSync_ff[1] : sdiSync_ff[1];
  assign sdaBit  = sdiSync_ff[1];
  assign i2cStart = csHigh & clkHigh & sdaPrev_ff & ~sdaBit;
  assign i2cStop  = csHigh & clkHigh & ~sdaPrev_ff & sdaBit;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < REG_COUNT; i++) regs_ff[i] <= 8'h00;
      regs_ff[sensor_port_pkg::POWER_CONTROL_ADDR] <=
        sensor_port_pkg::POWER_CONTROL_RST;
      regs_ff[sensor_port_pkg::SAMPLE_LAYOUT_CONFIG_ADDR] <=
        sensor_port_pkg::SAMPLE_LAYOUT_CONFIG_RST;
    end else if (regWrite) begin
      regs_ff[regAddr] <= regWdata;
    end
  end
  assign powerControl = regs_ff[sensor_port_pkg::POWER_CONTROL_ADDR];
  assign layoutConfig = regs_ff[sensor_port_pkg::SAMPLE_LAYOUT_CONFIG_ADDR];
  // standby only gates sampling; buffer is never cleared here
  assign measuring    = powerControl[sensor_port_pkg::MEASURE_BIT];
  assign sampleEnable = measuring;
  assign sampleClear  = 1'b0;
  // ****************************************
  // shared shift engine (spi and i2c)
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_CMD = 5'h02, ST_DATA = 5'h04,
    ST_ACK  = 5'h08, ST_SKIP = 5'h10
  } state_t;
  state_t     state_ff;
  logic [7:0] shift_ff, txByte_ff;
  logic [2:0] bitCnt_ff;
  logic [5:0] ptr_ff;
  logic       isRead_ff, burst_ff, i2c_ff, i2cAddrPhase_ff, i2cPtrSet_ff;
  logic       outBit_ff, driving_ff, sdaLow_ff, ackPend_ff;
  logic [7:0] rxByte;
  logic [6:0] myAddr;
  assign rxByte = {shift_ff[6:0], (i2c_ff ? sdaBit : dataBit)};
  assign myAddr = idSync_ff[1] ? sensor_port_pkg::I2C_ADDR_HIGH
                               : sensor_port_pkg::I2C_ADDR_LOW;
  assign regAddr  = ptr_ff;
  assign regWdata = rxByte;
  assign regWrite = (state_ff == ST_DATA) & clkRise & ~isRead_ff &
                    (bitCnt_ff == sensor_port_pkg::BIT_LAST) &
                    (~i2c_ff | i2cPtrSet_ff);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      txByte_ff <= 8'h00;
      bitCnt_ff <= 3'h0;
      ptr_ff <= 6'h00;
      isRead_ff <= 1'b0;
      burst_ff <= 1'b0;
      i2c_ff <= 1'b0;
      i2cAddrPhase_ff <= 1'b0;
      i2cPtrSet_ff <= 1'b0;
      ackPend_ff <= 1'b0;
    end else if (!csHigh && i2c_ff | (!csHigh && state_ff == ST_IDLE)) begin
      // chip-select low: spi frame begins, any i2c activity abandoned
      i2c_ff <= 1'b0;
      if (state_ff == ST_IDLE || i2c_ff) begin
        state_ff  <= ST_CMD;
        bitCnt_ff <= 3'h0;
      end
    end else if (csHigh && !i2c_ff && state_ff != ST_IDLE) begin
      state_ff <= ST_IDLE;
    end else if (i2cStart) begin
      i2c_ff <= 1'b1;
      i2cAddrPhase_ff <= 1'b1;
      state_ff <= ST_CMD;
      bitCnt_ff <= 3'h0;
    end else if (i2cStop) begin
      i2c_ff <= 1'b0;
      state_ff <= ST_IDLE;
    end else if (clkRise) begin
      case (state_ff)
        ST_CMD, ST_DATA: begin
          shift_ff  <= rxByte;
          bitCnt_ff <= bitCnt_ff + 3'h1;
          if (bitCnt_ff == sensor_port_pkg::BIT_LAST) begin
            if (i2c_ff) begin
              state_ff <= ST_ACK;
              ackPend_ff <= 1'b1;
              if (state_ff == ST_CMD && i2cAddrPhase_ff) begin
                i2cAddrPhase_ff <= 1'b0;
                isRead_ff <= rxByte[0];
                if (rxByte[7:1] != myAddr) state_ff <= ST_SKIP;
                if (rxByte[0]) txByte_ff <= regs_ff[ptr_ff];
                i2cPtrSet_ff <= rxByte[0];
              end else if (!i2cPtrSet_ff) begin
                ptr_ff <= rxByte[5:0];
                i2cPtrSet_ff <= 1'b1;
              end else begin
                ptr_ff <= ptr_ff + 6'h01;
                txByte_ff <= regs_ff[6'(ptr_ff + 6'h01)];
              end
            end else if (state_ff == ST_CMD) begin
              isRead_ff <= rxByte[sensor_port_pkg::RW_BIT];
              burst_ff  <= rxByte[sensor_port_pkg::BURST_BIT];
              ptr_ff    <= rxByte[5:0];
              txByte_ff <= regs_ff[rxByte[5:0]];
              state_ff  <= ST_DATA;
            end else if (burst_ff) begin
              ptr_ff <= ptr_ff + 6'h01;
              txByte_ff <= regs_ff[6'(ptr_ff + 6'h01)];
            end else begin
              state_ff <= ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          ackPend_ff <= 1'b0;
          state_ff <= ST_DATA;
        end
        default: ;
      endcase
    end
  end
  // ****************************************
  // output drivers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      outBit_ff <= 1'b1;
      driving_ff <= 1'b0;
      sdaLow_ff <= 1'b0;
    end else if (csHigh && !i2c_ff) begin
      driving_ff <= 1'b0;
      sdaLow_ff  <= 1'b0;
    end else if (clkFall) begin
      driving_ff <= ~i2c_ff & (state_ff == ST_DATA) & isRead_ff;
      outBit_ff  <= txByte_ff[3'(sensor_port_pkg::BIT_LAST - bitCnt_ff)];
      // i2c: pull low for ack, or for a 0 data bit during reads
      sdaLow_ff  <= i2c_ff & ((state_ff == ST_ACK) |
                   ((state_ff == ST_DATA) & isRead_ff &
                    ~txByte_ff[3'(sensor_port_pkg::BIT_LAST - bitCnt_ff)]));
    end
  end
  // device only ever answers; it never drives clock or starts a frame
  assign link.sdoOut  = outBit_ff;
  assign link.sdoOeN  = ~(driving_ff & ~wire3);
  assign link.sdioOut = outBit_ff;
  assign link.sdioOeN = ~(driving_ff & wire3);
  assign link.sdaOeN  = ~sdaLow_ff;
endmodule : sensor_port_device

// >>> hdl/sensor_port_host.sv
// Purpose: spi master for the sensor port, mode 3, burst capable
// Assumes: one transfer at a time; host holds cmd inputs while busy
// Notes:   clock derived by divider; write-phase readback discarded
module sensor_port_host #(
  parameter int MAX_BYTES = 8
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // link
  sensor_link_if.host     link,
  // command port
  input  wire logic       start,
  input  wire logic       isRead,
  input  wire logic       wire3,
  input  wire logic       idSelect,
  input  wire logic [5:0] addr,
  input  wire logic [3:0] byteCount,
  input  wire logic [7:0] wdata,
  output logic            wdataTake,
  output logic [7:0]      rdata,
  output logic            rdataValid,
  output logic            busy
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h1, H_SHIFT = 3'h2, H_GAP = 3'h4
  } hstate_t;
  hstate_t    state_ff;
  logic [3:0] div_ff, left_ff;
  logic [2:0] bit_ff;
  logic [7:0] tx_ff, rx_ff;
  logic       sclk_ff, cs_ff, first_ff, read_ff, pend_ff;
  logic [1:0] inSync_ff;
  logic       inBit;
  logic [7:0] rxNext;
  assign inBit  = wire3 ? link.sdioIn : link.sdoOut;
  assign rxNext = {rx_ff[6:0], inSync_ff[1]};
  always_ff @(posedge sys_clk) begin
    if (sys_rst) inSync_ff <= 2'h3;
    else         inSync_ff <= {inSync_ff[0], inBit};
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff   <= H_IDLE;
      div_ff     <= 4'h0;
      left_ff    <= 4'h0;
      bit_ff     <= 3'h0;
      tx_ff      <= 8'h00;
      rx_ff      <= 8'h00;
      rdata      <= 8'h00;
      sclk_ff    <= 1'b1;
      cs_ff      <= 1'b1;
      first_ff   <= 1'b0;
      read_ff    <= 1'b0;
      pend_ff    <= 1'b0;
      rdataValid <= 1'b0;
      wdataTake  <= 1'b0;
    end else begin
      rdataValid <= 1'b0;
      wdataTake  <= 1'b0;
      case (state_ff)
        H_IDLE: begin
          if (start) begin
            cs_ff    <= 1'b0;
            tx_ff    <= {isRead, (byteCount > 4'h1), addr};
            left_ff  <= byteCount;
            read_ff  <= isRead;
            first_ff <= 1'b1;
            pend_ff  <= 1'b0;
            bit_ff   <= 3'h0;
            div_ff   <= 4'h0;
            state_ff <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div_ff <= div_ff + 4'h1;
          // 320 ns link period keeps well above the rate minimum
          if (div_ff == sensor_port_pkg::HALF_DIV - 4'h1) begin
            div_ff  <= 4'h0;
            sclk_ff <= ~sclk_ff;
            if (!sclk_ff) begin
              pend_ff <= 1'b1;
            end else if (pend_ff) begin
              // data moves only on falling edges, never at the sampling edge;
              // answer is taken late since it returns through two sync stages
              rx_ff   <= rxNext;
              tx_ff   <= {tx_ff[6:0], 1'b0};
              bit_ff  <= bit_ff + 3'h1;
              pend_ff <= 1'b0;
              if (bit_ff == sensor_port_pkg::BIT_LAST) begin
                if (!first_ff && read_ff) begin
                  rdata      <= rxNext;
                  rdataValid <= 1'b1;
                end
                if (!first_ff) begin
                  left_ff <= left_ff - 4'h1;
                end
                first_ff <= 1'b0;
                if (!first_ff && left_ff == 4'h1) begin
                  // last byte: no further falling edge, clock stays high
                  sclk_ff  <= 1'b1;
                  state_ff <= H_GAP;
                end else if (!read_ff) begin
                  tx_ff     <= wdata;
                  wdataTake <= 1'b1;
                end
              end
            end
          end
        end
        H_GAP: begin
          cs_ff <= 1'b1;
          div_ff <= div_ff + 4'h1;
          if (div_ff == sensor_port_pkg::HALF_DIV) state_ff <= H_IDLE;
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end
  assign link.csN  = cs_ff;
  assign link.sclk = sclk_ff;
  // data-in held high while deselected so no i2c start appears
  assign link.sdi  = tx_ff[sensor_port_pkg::BIT_LAST] | cs_ff;
  assign link.busIdSelectPin = idSelect;
  assign busy = (state_ff != H_IDLE);
endmodule : sensor_port_host

// >>> include/sensor_link_if.sv
// Purpose: link pins between the sensor port and its master
// Assumes: testbench resolves shared data wire from the enables
// Notes:   enables are active low (low while driving)
interface sensor_link_if;
  logic csN;
  logic sclk;
  logic sdi;
  logic sdioIn;
  logic sdioOut;
  logic sdioOeN;
  logic sdoOut;
  logic sdoOeN;
  logic sdaIn;
  logic sdaOeN;
  logic busIdSelectPin;
  modport device (
    input  csN, sclk, sdi, sdioIn, sdaIn, busIdSelectPin,
    output sdioOut, sdioOeN, sdoOut, sdoOeN, sdaOeN
  );
  modport host (
    output csN, sclk, sdi, busIdSelectPin,
    input  sdioIn, sdoOut, sdoOeN
  );
endinterface : sensor_link_if

// >>> include/sensor_port_pkg.sv
// Purpose: shared constants for the sensor serial host port
// Assumes: link pins sampled by sys_clk (25 MHz)
// Notes:   register offsets, field positions, frame layout, addresses
package sensor_port_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [5:0] POWER_CONTROL_ADDR        = 6'h2D;
  localparam logic [5:0] SAMPLE_LAYOUT_CONFIG_ADDR = 6'h31;
  localparam int         MEASURE_BIT               = 3;
  localparam int         WIRE3_BIT                 = 6;
  localparam logic [7:0] POWER_CONTROL_RST         = 8'h00;
  localparam logic [7:0] SAMPLE_LAYOUT_CONFIG_RST  = 8'h00;
  // ****************************************
  // command byte and frame layout
  // ****************************************
  localparam int         RW_BIT     = 7;
  localparam int         BURST_BIT  = 6;
  localparam int         BYTE_BITS  = 8;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  // ****************************************
  // i2c slave addresses
  // ****************************************
  localparam logic [6:0] I2C_ADDR_HIGH = 7'h1D;
  localparam logic [6:0] I2C_ADDR_LOW  = 7'h53;
  // ****************************************
  // host clock divider (sys_clk cycles per half link period)
  // ****************************************
  localparam int         LINK_PERIOD_NS = 320;
  localparam int         SYS_PERIOD_NS  = 40;
  localparam logic [3:0] HALF_DIV =
    4'(LINK_PERIOD_NS / SYS_PERIOD_NS / 2);
endpackage : sensor_port_pkg

// >>> tb/sensor_serial_host_port_checker.sv
// Purpose: link checks between the host end and the device end
// Assumes: link pins sampled on sys_clk, host makes the link clock
// Notes:   watches interface signals only; frame tracking is helper logic
module sensor_serial_host_port_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // link
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdioOeN,
  input wire logic sdoOut,
  input wire logic sdoOeN,
  input wire logic sdaOeN
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // ****************************************
  // frame tracking
  // ****************************************
  logic [7:0] rises_ff;
  logic       readFlag_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || csN) begin
      rises_ff <= 8'h00;
    end else if ($rose(sclk) && rises_ff != 8'hFF) begin
      rises_ff <= rises_ff + 8'h01;
    end
  end
  // first rising edge of a frame carries the read flag
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      readFlag_ff <= 1'b0;
    end else if (!csN && rises_ff == 8'h00 && $rose(sclk)) begin
      readFlag_ff <= sdi;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_sclk_idle_high: assert property (csN |-> sclk)
    else $error("link clock low outside a frame");
  a_clock_in_frame: assert property ($fell(sclk) |-> !csN)
    else $error("link clock fell while deselected");
  a_cs_gap_kept: assert property ($rose(csN) |=> csN [*4])
    else $error("deselect gap too short");
  a_out_released: assert property (csN [*6] |-> sdoOeN && sdioOeN)
    else $error("data output still driven after deselect");
  a_shift_on_fall: assert property (!csN && !sdoOeN && $changed(sdoOut)
    |-> !sclk || !$past(sclk))
    else $error("data output changed away from a falling clock");
  a_one_data_pin: assert property (!sdioOeN |-> sdoOeN)
    else $error("both data outputs driven at once");
  a_no_i2c_in_spi: assert property (!csN |-> sdaOeN)
    else $error("i2c pull during an spi frame");
  a_read_only_drive: assert property ((!sdoOeN || !sdioOeN) && !csN
    |-> readFlag_ff && rises_ff >= 8'h08)
    else $error("device drove data outside a read data phase");
  // ****************************************
  // coverage
  // ****************************************
  c_four_wire_read: cover property (!csN && !sdoOeN);
  c_three_wire_read: cover property (!csN && !sdioOeN);
  c_long_frame: cover property (!csN && rises_ff == 8'h20);
endmodule : sensor_serial_host_port_checker

// >>> tb/sensor_serial_host_port_tb.sv
// Purpose: self-checking bench, host and device ends back to back
// Assumes: 25 MHz sys_clk; host derives the link clock
// Notes:   a mirror array of the register file predicts every read
module sensor_serial_host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       start = 1'b0, isRead = 1'b0, wire3 = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [3:0] byteCount = 4'h1;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, powerControl, layoutConfig;
  logic       wdataTake, rdataValid, busy;
  logic       measuring, sampleEnable, sampleClear;
  logic [7:0] mem [64];
  logic [7:0] seq [16];
  int         miscompares = 0;
  int         nChecks = 0;
  always #20 sys_clk = ~sys_clk;
  // ****************************************
  // link and ends
  // ****************************************
  sensor_link_if link ();
  // shared 3-wire pin: device wins while it drives
  assign link.sdioIn = link.sdioOeN ? link.sdi : link.sdioOut;
  assign link.sdaIn  = link.sdaOeN ? link.sdi : 1'b0;
  sensor_port_device sensor_port_device_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .link(link.device), .measuring(measuring),
    .sampleEnable(sampleEnable), .sampleClear(sampleClear),
    .powerControl(powerControl), .layoutConfig(layoutConfig));
  sensor_port_host sensor_port_host_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .link(link.host), .start(start), .isRead(isRead),
    .wire3(wire3), .idSelect(1'b1), .addr(addr), .byteCount(byteCount),
    .wdata(wdata), .wdataTake(wdataTake), .rdata(rdata),
    .rdataValid(rdataValid), .busy(busy));
  sensor_serial_host_port_checker sensor_serial_host_port_checker_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .csN(link.csN),
    .sclk(link.sclk), .sdi(link.sdi), .sdioOeN(link.sdioOeN),
    .sdoOut(link.sdoOut), .sdoOeN(link.sdoOeN), .sdaOeN(link.sdaOeN));
  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [7:0] expect_at(input logic [5:0] a, int k);
    return mem[6'(a + k)];
  endfunction : expect_at
  task automatic chk(input string what, input logic [7:0] seen, exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // one whole frame; writes also update the mirror
  task automatic xfer(input logic rd, w3, input logic [5:0] a, int n);
    int k;
    int t;
    k = 0;
    t = 0;
    @(posedge sys_clk);
    isRead <= rd;
    wire3 <= w3;
    addr <= a;
    byteCount <= 4'(n);
    wdata <= seq[0];
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    do begin
      @(negedge sys_clk);
      t++;
      if (rd && rdataValid) begin
        chk("rdata", rdata, expect_at(a, k));
        k++;
      end
      if (!rd && wdataTake) begin
        k++;
        @(posedge sys_clk);
        wdata <= seq[k];
      end
    end while ((busy || t < 3) && t < 1000);
    if (t >= 1000) begin
      miscompares++;
    end
    chk("byte count", 8'(k), 8'(n));
    if (!rd) begin
      for (int i = 0; i < n; i++) mem[6'(a + i)] = seq[i];
    end
    repeat (8) @(posedge sys_clk);
  endtask : xfer
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    int         n;
    logic [5:0] a;
    void'($urandom(32'h684a));
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    chk("powerControl", powerControl,
      sensor_port_pkg::POWER_CONTROL_RST);
    chk("layoutConfig", layoutConfig,
      sensor_port_pkg::SAMPLE_LAYOUT_CONFIG_RST);
    chk("measuring", {7'h00, measuring}, 8'h00);
    // burst that walks into the power control register
    seq[0] = 8'hA5;
    seq[1] = 8'h3C;
    seq[2] = 8'h01 << sensor_port_pkg::MEASURE_BIT;
    xfer(1'b0, 1'b0, 6'h2B, 3);
    chk("powerControl", powerControl, 8'h08);
    chk("measuring", {7'h00, measuring}, 8'h01);
    chk("sampleEnable", {7'h00, sampleEnable}, 8'h01);
    xfer(1'b1, 1'b0, 6'h2B, 3);
    seq[0] = 8'h00;
    xfer(1'b0, 1'b0, sensor_port_pkg::POWER_CONTROL_ADDR, 1);
    chk("measuring", {7'h00, measuring}, 8'h00);
    chk("sampleClear", {7'h00, sampleClear}, 8'h00);
    // random 4-wire traffic, then 3-wire after the wire-count bit
    for (int m = 0; m < 20; m++) begin
      if (m == 12) begin
        seq[0] = 8'h01 << sensor_port_pkg::WIRE3_BIT;
        xfer(1'b0, 1'b0, sensor_port_pkg::SAMPLE_LAYOUT_CONFIG_ADDR, 1);
        chk("layoutConfig", layoutConfig, 8'h40);
      end
      a = 6'($urandom_range(39));
      n = $urandom_range(4, 1);
      foreach (seq[i]) seq[i] = 8'($urandom);
      xfer(1'b0, 1'(m >= 12), a, n);
      xfer(1'b1, 1'(m >= 12), a, n);
    end
    print_verdict();
  end
  // hang guard, well beyond the expected run length
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end
endmodule : sensor_serial_host_port_tb
